// ==== rtl/cfs_sequencer.sv ====
// Purpose: Sequencer of a flow_program of two-word instructions
// Assumes: All ports share REF_CLK_I; memory answers with IMEM_VALID_I
// Notes:   One wavefront; clauses run in external execution units
`timescale 1ns/100ps
`include "cfs_defs.svh"
module cfs_sequencer
(
	input  wire logic                REF_CLK_I,
	input  wire logic                RST_I,
	input  wire logic                START_I,
	input  wire logic [31:0]         PGM_BASE_I,
	input  wire cfs_pkg::cfs_mask_t  ACT_MASK_I,
	input  wire cfs_pkg::cfs_mask_t  PRED_I,
	output logic                     IMEM_REQ_O,
	output logic [31:0]              IMEM_ADDR_O,
	input  wire logic                IMEM_VALID_I,
	input  wire logic [31:0]         IMEM_DATA_I,
	output logic                     CLAUSE_VALID_O,
	output cfs_pkg::cfs_clause_s     CLAUSE_O,
	input  wire logic                CLAUSE_READY_I,
	input  wire logic                CLAUSE_IDLE_I,
	output logic [4:0]               LCONST_SEL_O,
	input  wire cfs_pkg::cfs_lconst_s LCONST_I,
	output logic [7:0]               LOOP_INDEX_O,
	output logic                     WSYNC_REQ_O,
	input  wire logic                WSYNC_GO_I,
	output cfs_pkg::cfs_event_s      EVENT_O,
	output cfs_pkg::cfs_mask_t       ACTIVE_MASK_O,
	output logic                     BUSY_O,
	output logic                     HALTED_O
);
	import cfs_pkg::*;

	cfs_top_s   st_reg;
	cfs_top_s   st_next;
	cfs_instr_s ins;
	cfs_entry_s stk_top;
	cfs_entry_s stk_din;
	logic       stk_push;
	logic       stk_pop;
	logic       stk_wr;
	logic       stk_full;
	logic       stk_empty;
	logic       fault;
	logic       go;
	cfs_mask_t  cmask;
	cfs_mask_t  left;
	cfs_pc_t    pc_inc;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte address of one word of an instruction pair
	function automatic logic [31:0] word_addr(logic [31:0] b, cfs_pc_t pc, logic hi);
		word_addr = b + {17'h00000, pc, hi, 2'h0};
	endfunction

	// Pixels that pass a condition
	function automatic cfs_mask_t cond_mask(logic [1:0] c, cfs_mask_t m, cfs_mask_t p);
		unique case (c)
			`CFS_COND_ALWAYS, `CFS_COND_ACTIVE: cond_mask = m;
			`CFS_COND_PRED:                     cond_mask = m & p;
			`CFS_COND_PRED_N:                   cond_mask = m & ~p;
		endcase
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	cfs_decode u_dec
	(
		.lo_i  (st_reg.lo),
		.hi_i  (st_reg.hi),
		.ins_o (ins)
	);

	cfs_stack u_stk
	(
		.clk_i   (REF_CLK_I),
		.rst_i   (RST_I),
		.push_i  (stk_push),
		.pop_i   (stk_pop),
		.wr_i    (stk_wr),
		.din_i   (stk_din),
		.top_o   (stk_top),
		.full_o  (stk_full),
		.empty_o (stk_empty)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign IMEM_REQ_O     = st_reg.state == S_FETCH_LO || st_reg.state == S_FETCH_HI;
	assign IMEM_ADDR_O    = word_addr(st_reg.base, st_reg.pc, st_reg.state == S_FETCH_HI);
	assign CLAUSE_VALID_O = st_reg.state == S_ISSUE;
	assign CLAUSE_O       = st_reg.cl;
	assign LCONST_SEL_O   = ins.cidx;
	assign LOOP_INDEX_O   = stk_top.idx;
	assign WSYNC_REQ_O    = st_reg.state == S_SYNC;
	assign EVENT_O        = st_reg.ev;
	assign ACTIVE_MASK_O  = st_reg.mask;
	assign BUSY_O         = st_reg.state != S_IDLE && st_reg.state != S_ERR;
	assign HALTED_O       = st_reg.state == S_ERR;

	// Common terms of the execute step
	assign go     = st_reg.state == S_EXEC && (!ins.ord || CLAUSE_IDLE_I);
	assign cmask  = cond_mask(ins.cond, st_reg.mask, PRED_I);
	assign left   = st_reg.mask & ~cmask;
	assign pc_inc = st_reg.pc + `CFS_PC_ONE;

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb
	begin
		st_next  = st_reg;
		st_next.ev = '0;
		stk_push = 1'b0;
		stk_pop  = 1'b0;
		stk_wr   = 1'b0;
		stk_din  = stk_top;
		fault    = 1'b0;
		unique case (st_reg.state)
			S_IDLE, S_ERR:
				if (START_I)
				begin
					st_next.pc    = `CFS_PC_RESET;
					st_next.base  = PGM_BASE_I;
					st_next.mask  = ACT_MASK_I;
					st_next.state = S_FETCH_LO;
				end
			S_FETCH_LO:
				if (IMEM_VALID_I)
				begin
					st_next.lo    = IMEM_DATA_I;
					st_next.state = S_FETCH_HI;
				end
			S_FETCH_HI:
				if (IMEM_VALID_I)
				begin
					st_next.hi    = IMEM_DATA_I;
					st_next.state = S_EXEC;
				end
			S_EXEC:
				if (go)
				begin
					st_next.pc    = pc_inc;
					st_next.state = S_FETCH_LO;
					unique case (ins.op)
						`CFS_OP_NOP:
							st_next.pc = pc_inc;
						`CFS_OP_ALU, `CFS_OP_ALU_SYNC, `CFS_OP_TEX, `CFS_OP_GDS,
						`CFS_OP_TEX_FS:
						begin
							// Clause launch: kind, start, entries plus one
							st_next.cl.kind = (ins.op == `CFS_OP_TEX || ins.op == `CFS_OP_TEX_FS)
								? C_TEX : (ins.op == `CFS_OP_GDS) ? C_GDS : C_ALU;
							st_next.cl.addr = (ins.op == `CFS_OP_TEX_FS)
								? `CFS_FS_ADDR : ins.addr;
							st_next.cl.num  = {1'b0, ins.cnt} + 8'h01;
							st_next.cl.mask = cmask;
							st_next.cl.ord  = ins.ord;
							st_next.cl.sync = ins.op == `CFS_OP_ALU_SYNC;
							if (ins.cond == `CFS_COND_ALWAYS || cmask != '0)
								st_next.state = S_ISSUE;
						end
						`CFS_OP_LOOP_IDX, `CFS_OP_LOOP_REP, `CFS_OP_LOOP_FREE:
						begin
							// Open a loop frame; a zero trip count jumps past the end, except for a free loop
							stk_din.kind = (ins.op == `CFS_OP_LOOP_FREE) ? K_LOOP_FREE : K_LOOP;
							stk_din.mask = st_reg.mask;
							stk_din.live = st_reg.mask;
							stk_din.cnt  = LCONST_I.count;
							stk_din.idx  = (ins.op == `CFS_OP_LOOP_IDX) ? LCONST_I.init : 8'h00;
							stk_din.inc  = (ins.op == `CFS_OP_LOOP_IDX) ? LCONST_I.inc : 8'h00;
							stk_din.addr = ins.addr;
							if (ins.op != `CFS_OP_LOOP_FREE && LCONST_I.count == 8'h00)
								st_next.pc = ins.addr + `CFS_PC_ONE;
							else if (stk_full)
								fault = 1'b1;
							else
								stk_push = 1'b1;
						end
						`CFS_OP_LOOP_END:
							if (stk_empty || stk_top.kind == K_MASK || stk_top.kind == K_RET)
								fault = 1'b1;
							else if ((stk_top.kind == K_LOOP_FREE || stk_top.cnt != 8'h01)
								&& stk_top.live != '0)
							begin
								// Next iteration with the pixels that did not break
								stk_wr        = 1'b1;
								stk_din.cnt   = stk_top.cnt - 8'h01;
								stk_din.idx   = stk_top.idx + stk_top.inc;
								st_next.mask  = stk_top.live;
								st_next.pc    = ins.addr + `CFS_PC_ONE;
							end
							else
							begin
								stk_pop      = 1'b1;
								st_next.mask = stk_top.mask;
							end
						`CFS_OP_BREAK:
							if (stk_empty)
								fault = 1'b1;
							else
							begin
								// Broken pixels leave this and all later iterations
								stk_wr       = 1'b1;
								stk_din.live = stk_top.live & ~cmask;
								st_next.mask = left;
								if (left == '0)
									st_next.pc = ins.addr;
							end
						`CFS_OP_CONT:
						begin
							// Continuing pixels sleep until the loop end
							st_next.mask = left;
							if (left == '0)
								st_next.pc = ins.addr;
						end
						`CFS_OP_CALL:
							if (cmask != '0)
							begin
								stk_din.kind = K_RET;
								stk_din.mask = st_reg.mask;
								stk_din.addr = pc_inc;
								if (stk_full)
									fault = 1'b1;
								else
								begin
									stk_push     = 1'b1;
									st_next.mask = cmask;
									st_next.pc   = ins.addr;
								end
							end
						`CFS_OP_RET:
							if (stk_empty)
								fault = 1'b1;
							else
							begin
								stk_pop      = 1'b1;
								st_next.mask = stk_top.mask;
								st_next.pc   = stk_top.addr;
							end
						`CFS_OP_PUSH:
						begin
							stk_din.kind = K_MASK;
							stk_din.mask = st_reg.mask;
							if (stk_full)
								fault = 1'b1;
							else
								stk_push = 1'b1;
						end
						`CFS_OP_POP:
							if (stk_empty)
								fault = 1'b1;
							else
							begin
								stk_pop      = 1'b1;
								st_next.mask = stk_top.mask;
							end
						`CFS_OP_ELSE:
							st_next.mask = (stk_empty ? '1 : stk_top.mask) & ~st_reg.mask;
						`CFS_OP_JUMP:
							if (ins.cond == `CFS_COND_ALWAYS || cmask == '0)
								st_next.pc = ins.addr;
						`CFS_OP_EMIT, `CFS_OP_EMIT_CUT:
						begin
							st_next.ev.emit = 1'b1;
							st_next.ev.cut  = ins.op == `CFS_OP_EMIT_CUT;
						end
						`CFS_OP_CUT:
							st_next.ev.cut = 1'b1;
						`CFS_OP_WSYNC:
							st_next.state = S_SYNC;
						`CFS_OP_IRQ:
							st_next.ev.irq = 1'b1;
						`CFS_OP_PRIO_UP:
							st_next.ev.prio_up = 1'b1;
						`CFS_OP_PRIO_DN:
							st_next.ev.prio_dn = 1'b1;
						`CFS_OP_LDS_FREE:
							st_next.ev.lds_free = 1'b1;
						`CFS_OP_END:
							st_next.state = S_END;
						default:
							fault = 1'b1;
					endcase
				end
			S_ISSUE:
				if (CLAUSE_READY_I)
					st_next.state = S_FETCH_LO;
			S_SYNC:
				if (WSYNC_GO_I)
					st_next.state = S_FETCH_LO;
			S_END:
				if (CLAUSE_IDLE_I)
				begin
					st_next.state   = S_IDLE;
					st_next.ev.done = 1'b1;
				end
		endcase
		// Stack misuse or an unknown opcode halts the wavefront
		if (fault)
		begin
			st_next.state  = S_ERR;
			st_next.pc     = st_reg.pc;
			st_next.ev.err = 1'b1;
			stk_push       = 1'b0;
			stk_pop        = 1'b0;
			stk_wr         = 1'b0;
		end
	end

	// State register
	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	property p_jump;
		go && ins.op == `CFS_OP_JUMP && ins.cond == `CFS_COND_ALWAYS |=> st_reg.pc == $past(ins.addr);
	endproperty
	a_jump: assert property (p_jump)
		else $error("Jump target not taken");

	property p_step;
		go && ins.op == `CFS_OP_NOP |=> st_reg.pc == $past(pc_inc) && IMEM_REQ_O;
	endproperty
	a_step: assert property (p_step)
		else $error("Counter did not step");

	property p_hi_word;
		st_reg.state == S_FETCH_LO && IMEM_VALID_I |=> IMEM_ADDR_O == $past(IMEM_ADDR_O) + 32'h4;
	endproperty
	a_hi_word: assert property (p_hi_word)
		else $error("High word not at plus four");

	property p_count;
		go && ins.op == `CFS_OP_ALU && ins.cond == `CFS_COND_ALWAYS
		|=> CLAUSE_VALID_O && CLAUSE_O.num == {1'b0, $past(ins.cnt)} + 8'h01;
	endproperty
	a_count: assert property (p_count)
		else $error("Clause size wrong");

	property p_skip;
		go && ins.op == `CFS_OP_ALU && ins.cond == `CFS_COND_ACTIVE && st_reg.mask == '0
		|=> !CLAUSE_VALID_O ##1 !CLAUSE_VALID_O;
	endproperty
	a_skip: assert property (p_skip)
		else $error("Empty conditional clause issued");

	property p_order;
		st_reg.state == S_EXEC && ins.ord && !CLAUSE_IDLE_I |=> st_reg.state == S_EXEC && $stable(st_reg.pc);
	endproperty
	a_order: assert property (p_order)
		else $error("Ordered instruction started early");

	property p_fs;
		go && ins.op == `CFS_OP_TEX_FS && ins.cond == `CFS_COND_ALWAYS
		|=> CLAUSE_O.addr == `CFS_FS_ADDR && CLAUSE_O.kind == C_TEX;
	endproperty
	a_fs: assert property (p_fs)
		else $error("Fetch subroutine used address field");

	property p_end;
		go && ins.op == `CFS_OP_END ##1 CLAUSE_IDLE_I |=> EVENT_O.done && !BUSY_O;
	endproperty
	a_end: assert property (p_end)
		else $error("Program did not end");

	property p_underflow;
		go && ins.op == `CFS_OP_POP && stk_empty |=> HALTED_O && EVENT_O.err;
	endproperty
	a_underflow: assert property (p_underflow)
		else $error("Underflow not flagged");

	property p_ret;
		go && ins.op == `CFS_OP_RET && !stk_empty |=> st_reg.pc == $past(stk_top.addr);
	endproperty
	a_ret: assert property (p_ret)
		else $error("Return address wrong");

	property p_emit;
		go && ins.op == `CFS_OP_EMIT_CUT |=> EVENT_O.emit && EVENT_O.cut ##1 !EVENT_O.emit;
	endproperty
	a_emit: assert property (p_emit)
		else $error("Emit pulse wrong");
endmodule // cfs_sequencer

// ==== pkg/cfs_defs.svh ====
// Purpose: Constants of the flow program sequencer
// Assumes: Included by the package and by every module that needs them
// Notes:   Opcodes other than the jump are local encodings
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CFS_LANES      16
`define CFS_PC_W       12
`define CFS_STK_DEPTH  4'h8
`define CFS_STK_PTR_W  4
`define CFS_NCONST     32
`define CFS_PC_RESET   12'h000
`define CFS_PC_ONE     12'h001
`define CFS_FS_ADDR    12'h000

// ----------------------------------------
// Field positions of the high word, and of the target in the low word
// ----------------------------------------
`define CFS_F_CNT_LSB   0
`define CFS_F_CNT_W     7
`define CFS_F_CONST_LSB 8
`define CFS_F_COND_LSB  13
`define CFS_F_OP_LSB    22
`define CFS_F_ORD_BIT   30
`define CFS_F_ADDR_LSB  0

// ----------------------------------------
// Opcodes of op_select_field
// ----------------------------------------
`define CFS_OP_NOP       8'h00
`define CFS_OP_ALU       8'h01
`define CFS_OP_TEX       8'h02
`define CFS_OP_GDS       8'h03
`define CFS_OP_TEX_FS    8'h04
`define CFS_OP_LOOP_IDX  8'h05
`define CFS_OP_LOOP_FREE 8'h06
`define CFS_OP_LOOP_REP  8'h07
`define CFS_OP_LOOP_END  8'h08
`define CFS_OP_BREAK     8'h09
`define CFS_OP_CONT      8'h0a
`define CFS_OP_CALL      8'h0b
`define CFS_OP_RET       8'h0c
`define CFS_OP_PUSH      8'h0d
`define CFS_OP_POP       8'h0e
`define CFS_OP_ELSE      8'h0f
`define CFS_OP_JUMP      8'h10
`define CFS_OP_EMIT      8'h11
`define CFS_OP_EMIT_CUT  8'h12
`define CFS_OP_CUT       8'h13
`define CFS_OP_WSYNC     8'h14
`define CFS_OP_IRQ       8'h15
`define CFS_OP_PRIO_UP   8'h16
`define CFS_OP_PRIO_DN   8'h17
`define CFS_OP_LDS_FREE  8'h18
`define CFS_OP_END       8'h19
`define CFS_OP_ALU_SYNC  8'h1a

// ----------------------------------------
// Condition codes
// ----------------------------------------
`define CFS_COND_ALWAYS 2'h0
`define CFS_COND_ACTIVE 2'h1
`define CFS_COND_PRED   2'h2
`define CFS_COND_PRED_N 2'h3

`endif

// ==== pkg/cfs_pkg.sv ====
// Purpose: Types of the flow program sequencer
// Assumes: cfs_defs.svh on the include path
// Notes:   All module state travels as packed structs
package cfs_pkg;
`include "cfs_defs.svh"

	typedef logic [`CFS_LANES-1:0] cfs_mask_t;
	typedef logic [`CFS_PC_W-1:0]  cfs_pc_t;

	typedef enum logic [1:0] {K_MASK, K_LOOP, K_LOOP_FREE, K_RET} cfs_kind_e;
	typedef enum logic [1:0] {C_ALU, C_TEX, C_GDS} cfs_ckind_e;
	typedef enum logic [3:0] {S_IDLE, S_FETCH_LO, S_FETCH_HI, S_EXEC, S_ISSUE, S_SYNC,
		S_END, S_ERR} cfs_state_e;

	typedef struct packed {
		cfs_kind_e  kind;
		cfs_mask_t  mask;
		cfs_mask_t  live;
		logic [7:0] cnt;
		logic [7:0] idx;
		logic [7:0] inc;
		cfs_pc_t    addr;
	} cfs_entry_s;

	typedef struct packed {
		logic [7:0] op;
		logic       ord;
		logic [1:0] cond;
		logic [4:0] cidx;
		logic [6:0] cnt;
		cfs_pc_t    addr;
	} cfs_instr_s;

	typedef struct packed {
		cfs_ckind_e kind;
		cfs_pc_t    addr;
		logic [7:0] num;
		cfs_mask_t  mask;
		logic       ord;
		logic       sync;
	} cfs_clause_s;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] init;
		logic [7:0] inc;
	} cfs_lconst_s;

	typedef struct packed {
		logic emit;
		logic cut;
		logic irq;
		logic prio_up;
		logic prio_dn;
		logic lds_free;
		logic done;
		logic err;
	} cfs_event_s;

	typedef struct packed {
		cfs_entry_s [`CFS_STK_DEPTH-1:0] mem;
		logic [`CFS_STK_PTR_W-1:0]       ptr;
	} cfs_stk_s;

	typedef struct packed {
		cfs_state_e  state;
		cfs_pc_t     pc;
		logic [31:0] base;
		logic [31:0] lo;
		logic [31:0] hi;
		cfs_mask_t   mask;
		cfs_clause_s cl;
		cfs_event_s  ev;
	} cfs_top_s;

endpackage

// ==== rtl/cfs_decode.sv ====
// Purpose: Splits a fetched word pair into instruction fields
// Assumes: Low word from +0, high word from +4
// Notes:   Purely combinational
`timescale 1ns/100ps
`include "cfs_defs.svh"
module cfs_decode
(
	input  wire logic [31:0]    lo_i,
	input  wire logic [31:0]    hi_i,
	output cfs_pkg::cfs_instr_s ins_o
);
	import cfs_pkg::*;

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	// Opcode, flags and counts sit in the high word, the target in the low word
	always_comb
	begin
		ins_o.op   = hi_i[`CFS_F_OP_LSB +: 8];
		ins_o.ord  = hi_i[`CFS_F_ORD_BIT];
		ins_o.cond = hi_i[`CFS_F_COND_LSB +: 2];
		ins_o.cidx = hi_i[`CFS_F_CONST_LSB +: 5];
		ins_o.cnt  = hi_i[`CFS_F_CNT_LSB +: `CFS_F_CNT_W];
		ins_o.addr = lo_i[`CFS_F_ADDR_LSB +: `CFS_PC_W];
	end
endmodule // cfs_decode

// ==== rtl/cfs_stack.sv ====
// Purpose: Shared stack for masks, loop counters and return addresses
// Assumes: Caller never pushes and pops in one cycle
// Notes:   Overflowing or underflowing requests are dropped
`timescale 1ns/100ps
`include "cfs_defs.svh"
module cfs_stack
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               push_i,
	input  wire logic               pop_i,
	input  wire logic               wr_i,
	input  wire cfs_pkg::cfs_entry_s din_i,
	output cfs_pkg::cfs_entry_s      top_o,
	output logic                     full_o,
	output logic                     empty_o
);
	import cfs_pkg::*;

	cfs_stk_s                    s_reg;
	cfs_stk_s                    s_next;
	logic [`CFS_STK_PTR_W-2:0]   top_idx;

	// ----------------------------------------
	// Pointer and top entry
	// ----------------------------------------
	assign top_idx = (`CFS_STK_PTR_W-1)'(s_reg.ptr - 4'h1);
	assign full_o  = s_reg.ptr == `CFS_STK_DEPTH;
	assign empty_o = s_reg.ptr == 4'h0;
	assign top_o   = s_reg.mem[top_idx];

	// Push, pop or rewrite of the top entry
	always_comb
	begin
		s_next = s_reg;
		if (push_i && !full_o)
		begin
			s_next.mem[s_reg.ptr[`CFS_STK_PTR_W-2:0]] = din_i;
			s_next.ptr = s_reg.ptr + 4'h1;
		end
		else if (pop_i && !empty_o)
			s_next.ptr = s_reg.ptr - 4'h1;
		else if (wr_i && !empty_o)
			s_next.mem[top_idx] = din_i;
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_push_top;
		@(posedge clk_i) disable iff (rst_i)
		push_i && !full_o |=> top_o == $past(din_i) && !empty_o;
	endproperty
	a_push_top: assert property (p_push_top)
		else $error("Pushed entry not on top");
endmodule // cfs_stack

// ==== bench/cfs_far_model.sv ====
// Purpose: Far side model: instruction memory, clause units, wave sync
// Assumes: Word index is byte address over four, 64 words
// Notes:   Idle data lines show the inverse of the last word
`timescale 1ns/100ps
module cfs_far_model
(
	input  wire logic            clk_i,
	input  wire logic            imem_req_i,
	input  wire logic [31:0]     imem_addr_i,
	output logic                 imem_valid_o,
	output logic [31:0]          imem_data_o,
	input  wire logic            clause_valid_i,
	output logic                 clause_ready_o,
	output logic                 clause_idle_o,
	input  wire logic [4:0]      lconst_sel_i,
	output cfs_pkg::cfs_lconst_s lconst_o,
	input  wire logic            wsync_req_i,
	output logic                 wsync_go_o
);
	logic [31:0] mem [0:63];
	logic [31:0] last = 32'h0;
	logic [1:0]  wait_cnt = 2'h0;
	initial clause_idle_o = 1'b1;
	initial wsync_go_o = 1'b0;
	// Memory answers in the request cycle
	assign imem_valid_o = imem_req_i;
	assign imem_data_o = imem_req_i ? mem[imem_addr_i[7:2]] : ~last;
	// Loop constant: count equals its index, start 0, step 1
	assign lconst_o = '{count: {3'h0, lconst_sel_i}, init: 8'h00, inc: 8'h01};
	// Clause units stall two cycles before accepting
	assign clause_ready_o = clause_valid_i && (wait_cnt == 2'h2);
	always @(posedge clk_i)
	begin
		if (imem_req_i)
			last <= imem_data_o;
		wait_cnt <= (clause_valid_i && !clause_ready_o) ? wait_cnt + 2'h1 : 2'h0;
		clause_idle_o <= !clause_valid_i;
		wsync_go_o <= wsync_req_i && !wsync_go_o;
	end
endmodule // cfs_far_model

// ==== bench/cfs_sequencer_bench.sv ====
// Purpose: Self-checking bench of the sequencer
// Assumes: Far side model serves memory, clauses and sync
// Notes:   Each scenario loads a program, runs it and judges results
`timescale 1ns/100ps
`include "cfs_defs.svh"
module cfs_sequencer_bench;
	import cfs_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic [31:0] base = 32'h100;
	cfs_mask_t   act = 16'hffff;
	cfs_mask_t   pred = 16'h00ff;
	logic        imem_req, imem_valid, cl_valid, cl_ready, cl_idle, wreq, wgo, busy, halted;
	logic [31:0] imem_addr, imem_data;
	logic [4:0]  lsel;
	logic [7:0]  lidx;
	cfs_mask_t   amask;
	logic [7:0]  ix_q[$];
	cfs_lconst_s lconst;
	cfs_clause_s clause;
	cfs_event_s  ev;
	cfs_event_s  ev_acc;
	cfs_clause_s cl_q[$];
	logic [31:0] ad_q[$];
	int          err_total = 0;
	int          checks = 0;

	cfs_sequencer i_dut (.REF_CLK_I(clk), .RST_I(rst), .START_I(start), .PGM_BASE_I(base),
		.ACT_MASK_I(act), .PRED_I(pred), .IMEM_REQ_O(imem_req), .IMEM_ADDR_O(imem_addr),
		.IMEM_VALID_I(imem_valid), .IMEM_DATA_I(imem_data), .CLAUSE_VALID_O(cl_valid),
		.CLAUSE_O(clause), .CLAUSE_READY_I(cl_ready), .CLAUSE_IDLE_I(cl_idle),
		.LCONST_SEL_O(lsel), .LCONST_I(lconst), .LOOP_INDEX_O(lidx), .WSYNC_REQ_O(wreq),
		.WSYNC_GO_I(wgo), .EVENT_O(ev), .ACTIVE_MASK_O(amask), .BUSY_O(busy),
		.HALTED_O(halted));
	cfs_far_model i_far (.clk_i(clk), .imem_req_i(imem_req), .imem_addr_i(imem_addr),
		.imem_valid_o(imem_valid), .imem_data_o(imem_data), .clause_valid_i(cl_valid),
		.clause_ready_o(cl_ready), .clause_idle_o(cl_idle), .lconst_sel_i(lsel),
		.lconst_o(lconst), .wsync_req_i(wreq), .wsync_go_o(wgo));

	// Clock of 40 ns
	always #20 clk = ~clk;
	// Collect accepted clauses, loop index, fetch addresses and event pulses mid-cycle
	always @(negedge clk)
	begin
		if (cl_valid && cl_ready)
		begin
			cl_q.push_back(clause);
			ix_q.push_back(lidx);
		end
		if (imem_req && imem_valid)
			ad_q.push_back(imem_addr);
		ev_acc = ev_acc | ev;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic put(input int pc, input logic [7:0] op, input logic [11:0] adr = 12'h0,
		input logic [6:0] cnt = 7'h0, input logic [4:0] ci = 5'h0,
		input logic [1:0] cnd = 2'h0, input logic ord = 1'b0);
		i_far.mem[2*pc] = {20'h0, adr};
		i_far.mem[2*pc+1] = {1'b0, ord, op, 7'h0, cnd, ci, 1'b0, cnt};
	endtask

	// Start the loaded program and wait for it to stop
	task automatic run(input cfs_mask_t m);
		int k;
		cl_q.delete();
		ad_q.delete();
		ix_q.delete();
		ev_acc = '0;
		act = m;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		@(negedge clk);
		for (k = 0; k < 500 && busy === 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		chk("stopped", 1, k < 500);
	endtask

	task automatic t_clause;
		put(0, `CFS_OP_ALU, 12'h005, 7'h03);
		put(1, `CFS_OP_TEX, 12'h009, 7'h00, 5'h0, 2'h0, 1'b1);
		put(2, `CFS_OP_TEX_FS, 12'h0ab);
		put(3, `CFS_OP_GDS, 12'h011, 7'h7f);
		put(4, `CFS_OP_END);
		run(16'h00f0);
		chk("clauses", 4, cl_q.size());
		chk("alu_kind", C_ALU, cl_q[0].kind);
		chk("alu_addr", 5, cl_q[0].addr);
		chk("alu_num", 4, cl_q[0].num);
		chk("alu_mask", 16'h00f0, cl_q[0].mask);
		chk("tex_ord", 1, cl_q[1].ord);
		chk("fs_addr", `CFS_FS_ADDR, cl_q[2].addr);
		chk("gds_kind", C_GDS, cl_q[3].kind);
		chk("gds_num", 128, cl_q[3].num);
		chk("lo_addr", base, ad_q[0]);
		chk("hi_addr", base + 4, ad_q[1]);
		chk("next_pair", base + 8, ad_q[2]);
		chk("done", 1, ev_acc.done);
	endtask

	task automatic t_loop;
		put(0, `CFS_OP_LOOP_REP, 12'h002, 7'h0, 5'h02);
		put(1, `CFS_OP_ALU, 12'h007);
		put(2, `CFS_OP_LOOP_END, 12'h000);
		put(3, `CFS_OP_LOOP_IDX, 12'h005, 7'h0, 5'h00);
		put(4, `CFS_OP_ALU, 12'h009);
		put(5, `CFS_OP_LOOP_END, 12'h003);
		put(6, `CFS_OP_END);
		run(16'hffff);
		chk("loop_clauses", 2, cl_q.size());
		chk("loop_addr", 7, cl_q[1].addr);
	endtask

	task automatic t_call;
		put(0, `CFS_OP_CALL, 12'h003);
		put(1, `CFS_OP_JUMP, 12'h005);
		put(2, `CFS_OP_IRQ);
		put(3, `CFS_OP_EMIT);
		put(4, `CFS_OP_RET);
		put(5, `CFS_OP_END);
		run(16'hffff);
		chk("call_events", 8'h82, ev_acc);
	endtask

	task automatic t_events;
		for (int i = 0; i < 8; i++)
			put(i, 8'h12 + 8'(i));
		run(16'hffff);
		chk("events", 8'hfe, ev_acc);
	endtask

	// Free loop with breaks, indexed loop with continue, mask ops in a call
	task automatic t_mask;
		put(0, `CFS_OP_NOP);
		put(1, `CFS_OP_LOOP_FREE, 12'h005);
		put(2, `CFS_OP_BREAK, 12'h005, 7'h0, 5'h0, `CFS_COND_PRED);
		put(3, `CFS_OP_ALU_SYNC, 12'h003);
		put(4, `CFS_OP_BREAK, 12'h005);
		put(5, `CFS_OP_LOOP_END, 12'h001);
		put(6, `CFS_OP_LOOP_IDX, 12'h009, 7'h0, 5'h02);
		put(7, `CFS_OP_CONT, 12'h009, 7'h0, 5'h0, `CFS_COND_PRED);
		put(8, `CFS_OP_ALU, 12'h008);
		put(9, `CFS_OP_LOOP_END, 12'h006);
		put(10, `CFS_OP_CALL, 12'h00c, 7'h0, 5'h0, `CFS_COND_PRED);
		put(11, `CFS_OP_END);
		put(12, `CFS_OP_ELSE);
		put(13, `CFS_OP_PUSH);
		put(14, `CFS_OP_ELSE);
		put(15, `CFS_OP_ALU, 12'h00f, 7'h0, 5'h0, `CFS_COND_ACTIVE);
		put(16, `CFS_OP_POP);
		put(17, `CFS_OP_ALU, 12'h011);
		put(18, `CFS_OP_RET);
		run(16'hffff);
		chk("mask_clauses", 4, cl_q.size());
		chk("sync", 1, cl_q[0].sync);
		chk("break_mask", 16'hff00, cl_q[0].mask);
		chk("cont_mask", 16'hff00, cl_q[2].mask);
		chk("index0", 0, ix_q[1]);
		chk("index1", 1, ix_q[2]);
		chk("else_mask", 16'hff00, cl_q[3].mask);
		chk("sub_addr", 17, cl_q[3].addr);
		chk("end_mask", 16'hffff, amask);
		chk("mask_done", 1, ev_acc.done);
	endtask

	task automatic t_err;
		put(0, `CFS_OP_POP);
		run(16'hffff);
		chk("halted", 1, halted);
		chk("err_ev", 8'h01, ev_acc);
		put(0, `CFS_OP_ALU, 12'h0, 7'h0, 5'h0, `CFS_COND_ACTIVE);
		put(1, `CFS_OP_END, 12'h0, 7'h0, 5'h0, `CFS_COND_ACTIVE);
		run(16'h0000);
		chk("skipped", 0, cl_q.size());
		chk("cond_end", 1, ev_acc.done);
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_clause();
		t_loop();
		t_call();
		t_events();
		t_mask();
		t_err();
		print_verdict();
	end
	// Watchdog
	initial
	begin
		#800000;
		err_total++;
		print_verdict();
	end
endmodule // cfs_sequencer_bench
